// file: rtl/pid_pkg.sv
/*
 * constants for the closed-loop regulator: register offsets, field
 * positions, reset values, function codes and sample timing.
 * assumes a 32-bit apb slave with byte addresses and one word per register.
 */
package pid_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PI = 8'h04;
	localparam logic [7:0] ADDR_DI = 8'h08;
	localparam logic [7:0] ADDR_OUT = 8'h0C;
	localparam logic [7:0] ADDR_FG = 8'h10;
	localparam logic [7:0] ADDR_LOSS = 8'h14;
	localparam logic [7:0] ADDR_SLEEP = 8'h18;
	localparam logic [7:0] ADDR_RAMP = 8'h1C;
	localparam logic [7:0] ADDR_SETPT = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	localparam logic [7:0] ADDR_MON = 8'h28;
	localparam logic [7:0] ADDR_DINF = 8'h2C;
	localparam logic [7:0] ADDR_PSCALE = 8'h30;
	// control and status word field positions
	localparam int CTRL_METHOD_LSB = 0;
	localparam int CTRL_INVERT_BIT = 3;
	localparam int CTRL_NEGREV_BIT = 4;
	localparam int CTRL_REVPROH_BIT = 5;
	localparam int CTRL_LOSSMODE_LSB = 6;
	localparam int CTRL_RUN_BIT = 8;
	localparam int CTRL_RESETCMD_BIT = 9;
	localparam int CTRL_AINA_LSB = 12;
	localparam int CTRL_AINB_LSB = 16;
	localparam int CTRL_PULSE_LSB = 20;
	localparam int STAT_ACTIVE_BIT = 16;
	localparam int STAT_SLEEP_BIT = 17;
	localparam int STAT_WARN_BIT = 18;
	localparam int STAT_FAULT_BIT = 19;
	localparam int STAT_COMP_BIT = 20;
	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] PI_RESET = 32'h0000_0100;
	localparam logic [31:0] DI_RESET = 32'h2710_0000;
	localparam logic [31:0] OUT_RESET = 32'h0000_2710;
	localparam logic [31:0] FG_RESET = 32'h0100_0000;
	localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
	localparam logic [31:0] PSCALE_RESET = 32'h0000_0100;
	// function codes
	localparam logic [2:0] METHOD_ERR_FREQ = 3'h1;
	localparam logic [2:0] METHOD_FB_FREQ = 3'h2;
	localparam logic [2:0] METHOD_ERR_COMP = 3'h3;
	localparam logic [2:0] METHOD_FB_COMP = 3'h4;
	localparam logic [3:0] AIN_FEEDBACK = 4'hB;
	localparam logic [1:0] PULSE_FEEDBACK = 2'h1;
	localparam logic [1:0] LOSS_WARN = 2'h1;
	localparam logic [1:0] LOSS_FAULT = 2'h2;
	localparam logic [7:0] DIN_DISABLE = 8'h13;
	localparam logic [7:0] DIN_INT_RESET = 8'h1E;
	localparam logic [7:0] DIN_INT_HOLD = 8'h1F;
	localparam logic [7:0] DIN_SOFT_OFF = 8'h22;
	// offset step is 0.1 %, internal unit is 0.01 %
	localparam logic signed [31:0] OFFSET_SCALE = 32'sh0000_000A;
	// sample tick timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SAMPLE_PERIOD_NS = 1000;
	localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);
	typedef enum logic [0:0] {AWAKE, ASLEEP} sleep_state_t;
endpackage

// file: rtl/pid_regulator.sv
/*
 * closed-loop regulator with feedback select, pid, limits, offset, filter,
 * polarity, gain, reverse clamp, setpoint soft starter, feedback loss
 * detection and sleep, with an apb register file.
 * assumes pins analog_*, pulse_freq and din are asynchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module pid_regulator (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] analog_a_in,
	input wire logic [15:0] analog_b_in,
	input wire logic [15:0] pulse_freq_in,
	input wire logic [3:0] din,
	output logic [15:0] pid_output,
	output logic output_is_compensation,
	output logic drive_run,
	output logic fault_contact,
	output logic feedback_lost_alarm
);
	logic [31:0] ctrl_reg, pi_reg, di_reg, out_reg, fg_reg, loss_reg, sleep_reg;
	logic [31:0] ramp_reg, setpt_reg, dinf_reg, pscale_reg;
	logic [15:0] ain_a_s1, ain_a_s2, ain_b_s1, ain_b_s2, pulse_s1, pulse_s2;
	logic [3:0] din_s1, din_s2;
	logic [7:0] tick_cnt_reg;
	logic tick_reg, reset_cmd_reg, pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;
	logic signed [31:0] sp_ramp_reg, i_acc_reg, prev_err_reg, prev_fb_reg, filt_reg;
	logic [15:0] pid_out_reg;
	logic comp_reg, run_out_reg, fault_reg, warn_reg, loss_cond_reg;
	logic [15:0] loss_cnt_reg, sleep_cnt_reg;
	pid_pkg::sleep_state_t sleep_state_reg;
	// control fields
	logic [2:0] regulator_method_select;
	logic output_polarity_invert, negative_output_reverse, reverse_prohibit;
	logic [1:0] feedback_loss_mode, pulse_input_function;
	logic run_cmd;
	logic [3:0] analog_in_a_function, analog_in_b_function;
	assign regulator_method_select = ctrl_reg[pid_pkg::CTRL_METHOD_LSB +: 3];
	assign output_polarity_invert = ctrl_reg[pid_pkg::CTRL_INVERT_BIT];
	assign negative_output_reverse = ctrl_reg[pid_pkg::CTRL_NEGREV_BIT];
	assign reverse_prohibit = ctrl_reg[pid_pkg::CTRL_REVPROH_BIT];
	assign feedback_loss_mode = ctrl_reg[pid_pkg::CTRL_LOSSMODE_LSB +: 2];
	assign run_cmd = ctrl_reg[pid_pkg::CTRL_RUN_BIT];
	assign analog_in_a_function = ctrl_reg[pid_pkg::CTRL_AINA_LSB +: 4];
	assign analog_in_b_function = ctrl_reg[pid_pkg::CTRL_AINB_LSB +: 4];
	assign pulse_input_function = ctrl_reg[pid_pkg::CTRL_PULSE_LSB +: 2];

	// sample tick divider
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (tick_cnt_reg == pid_pkg::SAMPLE_LAST);
			tick_cnt_reg <= (tick_cnt_reg == pid_pkg::SAMPLE_LAST) ? 8'h00 : tick_cnt_reg + 8'h01;
		end
	end

	// two-stage synchronisers for pin inputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ain_a_s1 <= 16'h0000;
			ain_a_s2 <= 16'h0000;
			ain_b_s1 <= 16'h0000;
			ain_b_s2 <= 16'h0000;
			pulse_s1 <= 16'h0000;
			pulse_s2 <= 16'h0000;
			din_s1 <= 4'h0;
			din_s2 <= 4'h0;
		end else begin
			ain_a_s1 <= analog_a_in;
			ain_a_s2 <= ain_a_s1;
			ain_b_s1 <= analog_b_in;
			ain_b_s2 <= ain_b_s1;
			pulse_s1 <= pulse_freq_in;
			pulse_s2 <= pulse_s1;
			din_s1 <= din;
			din_s2 <= din_s1;
		end
	end

	// decode multi-function digital inputs by their function codes
	logic din_disable, din_int_reset, din_int_hold, din_soft_off;
	always_comb begin
		din_disable = 1'b0;
		din_int_reset = 1'b0;
		din_int_hold = 1'b0;
		din_soft_off = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (din_s2[i]) begin
				if (dinf_reg[8*i +: 8] == pid_pkg::DIN_DISABLE) din_disable = 1'b1;
				if (dinf_reg[8*i +: 8] == pid_pkg::DIN_INT_RESET) din_int_reset = 1'b1;
				if (dinf_reg[8*i +: 8] == pid_pkg::DIN_INT_HOLD) din_int_hold = 1'b1;
				if (dinf_reg[8*i +: 8] == pid_pkg::DIN_SOFT_OFF) din_soft_off = 1'b1;
			end
		end
	end

	// regulator enable and datapath
	logic active, int_clear, rev_clamp;
	logic signed [31:0] fb, err, p_term, i_next, d_diff, d_term, ilim, olim;
	logic signed [31:0] s_sum, s_lim, s_off, filt_next, s_inv, s_gain, s_rev;
	logic signed [47:0] p_prod, d_prod, g_prod, pulse_prod;
	always_comb begin
		active = (regulator_method_select >= pid_pkg::METHOD_ERR_FREQ) &&
			(regulator_method_select <= pid_pkg::METHOD_FB_COMP) && !din_disable;
		int_clear = din_int_reset || reset_cmd_reg || !drive_run || !active;
		pulse_prod = $signed({32'h0000_0000, pulse_s2}) * $signed({32'h0000_0000, pscale_reg[15:0]});
		if (analog_in_a_function == pid_pkg::AIN_FEEDBACK)
			fb = 32'($signed(ain_a_s2));
		else if (analog_in_b_function == pid_pkg::AIN_FEEDBACK)
			fb = 32'($signed(ain_b_s2));
		else if (pulse_input_function == pid_pkg::PULSE_FEEDBACK)
			fb = pulse_prod[39:8];
		else
			fb = 32'sh0000_0000;
		err = sp_ramp_reg - fb;
		p_prod = 48'(err) * $signed({32'h0000_0000, pi_reg[15:0]});
		p_term = p_prod[39:8];
		ilim = $signed({16'h0000, di_reg[31:16]});
		if (pi_reg[20:16] == 5'h00)
			i_next = 32'sh0000_0000;
		else
			i_next = i_acc_reg + (p_term >>> pi_reg[20:16]);
		if (i_next > ilim) i_next = ilim;
		if (i_next < -ilim) i_next = -ilim;
		// odd methods differentiate the error, even ones the feedback
		d_diff = regulator_method_select[0] ? (err - prev_err_reg) : (prev_fb_reg - fb);
		d_prod = 48'(d_diff) * $signed({32'h0000_0000, di_reg[15:0]});
		d_term = (di_reg[15:0] == 16'h0000) ? 32'sh0000_0000 : d_prod[39:8];
		s_sum = p_term + i_acc_reg + d_term;
		olim = $signed({16'h0000, out_reg[15:0]});
		s_lim = (s_sum > olim) ? olim : ((s_sum < -olim) ? -olim : s_sum);
		s_off = s_lim + 32'($signed(out_reg[31:16])) * pid_pkg::OFFSET_SCALE;
		filt_next = filt_reg + ((s_off - filt_reg) >>> fg_reg[3:0]);
		s_inv = output_polarity_invert ? -filt_reg : filt_reg;
		g_prod = 48'(s_inv) * $signed({32'h0000_0000, fg_reg[31:16]});
		s_gain = g_prod[39:8];
		rev_clamp = !negative_output_reverse || reverse_prohibit;
		s_rev = (rev_clamp && s_gain < 0) ? 32'sh0000_0000 : s_gain;
		if (s_rev > 32'sh0000_7FFF) s_rev = 32'sh0000_7FFF;
		if (s_rev < -32'sh0000_8000) s_rev = -32'sh0000_8000;
	end

	// apb write side; writes land at the completing access edge
	logic apb_done;
	assign apb_done = psel && penable && pready_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= pid_pkg::CTRL_RESET;
			pi_reg <= pid_pkg::PI_RESET;
			di_reg <= pid_pkg::DI_RESET;
			out_reg <= pid_pkg::OUT_RESET;
			fg_reg <= pid_pkg::FG_RESET;
			loss_reg <= pid_pkg::ZERO_RESET;
			sleep_reg <= pid_pkg::ZERO_RESET;
			ramp_reg <= pid_pkg::ZERO_RESET;
			setpt_reg <= pid_pkg::ZERO_RESET;
			dinf_reg <= pid_pkg::ZERO_RESET;
			pscale_reg <= pid_pkg::PSCALE_RESET;
			reset_cmd_reg <= 1'b0;
		end else begin
			reset_cmd_reg <= 1'b0;
			if (apb_done && pwrite) begin
				case (paddr)
					pid_pkg::ADDR_CTRL: begin
						ctrl_reg <= pwdata & ~(32'h0000_0001 << pid_pkg::CTRL_RESETCMD_BIT);
						reset_cmd_reg <= pwdata[pid_pkg::CTRL_RESETCMD_BIT];
					end
					pid_pkg::ADDR_PI: pi_reg <= pwdata;
					pid_pkg::ADDR_DI: di_reg <= pwdata;
					pid_pkg::ADDR_OUT: out_reg <= pwdata;
					pid_pkg::ADDR_FG: fg_reg <= pwdata;
					pid_pkg::ADDR_LOSS: loss_reg <= pwdata;
					pid_pkg::ADDR_SLEEP: sleep_reg <= pwdata;
					pid_pkg::ADDR_RAMP: ramp_reg <= pwdata;
					pid_pkg::ADDR_SETPT: setpt_reg <= pwdata;
					pid_pkg::ADDR_DINF: dinf_reg <= pwdata;
					pid_pkg::ADDR_PSCALE: pscale_reg <= pwdata;
					default: ;
				endcase
			end
		end
	end

	// apb answer: one wait state, read data and error registered
	logic [31:0] rd_word;
	logic rd_bad;
	always_comb begin
		rd_bad = 1'b0;
		case (paddr)
			pid_pkg::ADDR_CTRL: rd_word = ctrl_reg;
			pid_pkg::ADDR_PI: rd_word = {11'h000, pi_reg[20:0]};
			pid_pkg::ADDR_DI: rd_word = di_reg;
			pid_pkg::ADDR_OUT: rd_word = out_reg;
			pid_pkg::ADDR_FG: rd_word = {fg_reg[31:16], 12'h000, fg_reg[3:0]};
			pid_pkg::ADDR_LOSS: rd_word = loss_reg;
			pid_pkg::ADDR_SLEEP: rd_word = sleep_reg;
			pid_pkg::ADDR_RAMP: rd_word = {16'h0000, ramp_reg[15:0]};
			pid_pkg::ADDR_SETPT: rd_word = {16'h0000, setpt_reg[15:0]};
			pid_pkg::ADDR_STATUS: rd_word = {11'h000, comp_reg, fault_reg, warn_reg,
				sleep_state_reg == pid_pkg::ASLEEP, active, pid_out_reg};
			pid_pkg::ADDR_MON: rd_word = {sp_ramp_reg[15:0], fb[15:0]};
			pid_pkg::ADDR_DINF: rd_word = dinf_reg;
			pid_pkg::ADDR_PSCALE: rd_word = {16'h0000, pscale_reg[15:0]};
			default: begin
				rd_word = 32'h0000_0000;
				rd_bad = 1'b1;
			end
		endcase
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= psel && penable && !pready_reg;
			pslverr_reg <= psel && penable && !pready_reg && rd_bad;
			prdata_reg <= (psel && penable && !pready_reg && !pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	// setpoint soft starter
	logic signed [31:0] sp_target, sp_step;
	assign sp_target = 32'($signed(setpt_reg[15:0]));
	assign sp_step = $signed({16'h0000, ramp_reg[15:0]});
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sp_ramp_reg <= 32'sh0000_0000;
		end else if (tick_reg) begin
			if (din_soft_off || sp_step == 0)
				sp_ramp_reg <= sp_target;
			else if (sp_target > sp_ramp_reg + sp_step)
				sp_ramp_reg <= sp_ramp_reg + sp_step;
			else if (sp_target < sp_ramp_reg - sp_step)
				sp_ramp_reg <= sp_ramp_reg - sp_step;
			else
				sp_ramp_reg <= sp_target;
		end
	end

	// integral, derivative history, filter and output stage
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			i_acc_reg <= 32'sh0000_0000;
			prev_err_reg <= 32'sh0000_0000;
			prev_fb_reg <= 32'sh0000_0000;
			filt_reg <= 32'sh0000_0000;
			pid_out_reg <= 16'h0000;
			comp_reg <= 1'b0;
		end else begin
			if (int_clear)
				i_acc_reg <= 32'sh0000_0000;
			else if (tick_reg && !din_int_hold)
				i_acc_reg <= i_next;
			if (tick_reg) begin
				prev_err_reg <= err;
				prev_fb_reg <= fb;
				filt_reg <= active ? filt_next : 32'sh0000_0000;
				pid_out_reg <= active ? s_rev[15:0] : 16'h0000;
				comp_reg <= active && regulator_method_select >= pid_pkg::METHOD_ERR_COMP;
			end
		end
	end

	// feedback loss detection with restartable counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			loss_cnt_reg <= 16'h0000;
			loss_cond_reg <= 1'b0;
			warn_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			loss_cond_reg <= active && feedback_loss_mode != 2'h0 &&
				fb < $signed({16'h0000, loss_reg[15:0]});
			if (!loss_cond_reg)
				loss_cnt_reg <= 16'h0000;
			else if (tick_reg && loss_cnt_reg != loss_reg[31:16])
				loss_cnt_reg <= loss_cnt_reg + 16'h0001;
			if (loss_cond_reg && loss_cnt_reg == loss_reg[31:16] &&
					feedback_loss_mode == pid_pkg::LOSS_WARN)
				warn_reg <= 1'b1;
			else if (!loss_cond_reg || feedback_loss_mode != pid_pkg::LOSS_WARN)
				warn_reg <= 1'b0;
			// detection wins over a reset command in the same cycle
			if (loss_cond_reg && loss_cnt_reg == loss_reg[31:16] &&
					feedback_loss_mode == pid_pkg::LOSS_FAULT)
				fault_reg <= 1'b1;
			else if (reset_cmd_reg)
				fault_reg <= 1'b0;
		end
	end

	// sleep state machine with restartable delay counter
	logic sleep_cond;
	always_comb begin
		case (sleep_state_reg)
			pid_pkg::AWAKE: sleep_cond = sp_target < $signed({16'h0000, sleep_reg[15:0]});
			pid_pkg::ASLEEP: sleep_cond = sp_target > $signed({16'h0000, sleep_reg[15:0]});
			default: sleep_cond = 1'b0;
		endcase
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_state_reg <= pid_pkg::AWAKE;
			sleep_cnt_reg <= 16'h0000;
		end else if (!active || !run_cmd) begin
			sleep_state_reg <= pid_pkg::AWAKE;
			sleep_cnt_reg <= 16'h0000;
		end else if (!sleep_cond) begin
			sleep_cnt_reg <= 16'h0000;
		end else if (sleep_cnt_reg == sleep_reg[31:16]) begin
			sleep_cnt_reg <= 16'h0000;
			case (sleep_state_reg)
				pid_pkg::AWAKE: sleep_state_reg <= pid_pkg::ASLEEP;
				pid_pkg::ASLEEP: sleep_state_reg <= pid_pkg::AWAKE;
				default: sleep_state_reg <= pid_pkg::AWAKE;
			endcase
		end else if (tick_reg) begin
			sleep_cnt_reg <= sleep_cnt_reg + 16'h0001;
		end
	end

	// drive run and contact outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_out_reg <= 1'b0;
		end else begin
			run_out_reg <= run_cmd && !fault_reg && sleep_state_reg == pid_pkg::AWAKE;
		end
	end
	assign drive_run = run_out_reg;
	assign fault_contact = fault_reg;
	assign feedback_lost_alarm = warn_reg;
	assign pid_output = pid_out_reg;
	assign output_is_compensation = comp_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// checks
	apb_one_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
		psel && penable && !pready |=> pready) else $error("apb answer late");
	int_limit_a: assert property (@(posedge clk) disable iff (!reset_n)
		i_acc_reg <= ilim && i_acc_reg >= -ilim) else $error("integral beyond limit");
	deriv_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		di_reg[15:0] == 16'h0000 |-> d_term == 0) else $error("derivative not removed");
	rev_clamp_a: assert property (@(posedge clk) disable iff (!reset_n)
		tick_reg && rev_clamp |=> !pid_out_reg[15]) else $error("negative output leaked");
	int_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		int_clear |=> i_acc_reg == 0) else $error("integral not cleared");
	int_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		din_int_hold && !int_clear |=> $stable(i_acc_reg)) else $error("integral moved on hold");
	fault_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
		fault_reg |=> !drive_run) else $error("drive runs under fault");
	loss_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
		!loss_cond_reg |=> loss_cnt_reg == 16'h0000) else $error("loss counter kept");
	sleep_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		!active |=> sleep_state_reg == pid_pkg::AWAKE) else $error("asleep while disabled");
	ramp_bypass_a: assert property (@(posedge clk) disable iff (!reset_n)
		tick_reg && din_soft_off |=> sp_ramp_reg == $past(sp_target)) else $error("ramp not bypassed");
	warn_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
		warn_reg |-> $past(feedback_loss_mode) == pid_pkg::LOSS_WARN) else $error("warning in wrong mode");
endmodule
`default_nettype wire

// file: rtl/unused_none.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: dv/fb_sensor.sv
/*
 * process feedback sensor: puts one level on the chosen source.
 * assumes the bench picks src 0 analog a, 1 analog b, 2 pulse train.
 */
`timescale 1ns/1ns
`default_nettype none
module fb_sensor (
	input wire logic clk,
	input wire logic [1:0] src,
	input wire logic [15:0] level,
	output logic [15:0] analog_a_in,
	output logic [15:0] analog_b_in,
	output logic [15:0] pulse_freq_in
);
	logic [15:0] junk = 16'h5A5A;
	// unused channels show a pattern that moves every cycle
	always_ff @(posedge clk) begin
		junk <= junk + 16'h1357;
		analog_a_in <= (src == 2'h0) ? level : junk;
		analog_b_in <= (src == 2'h1) ? level : ~junk;
		pulse_freq_in <= (src == 2'h2) ? level : junk ^ 16'h0F0F;
	end
endmodule
`default_nettype wire

// file: dv/pid_regulator_loss_sleep_test.sv
/*
 * self-checking bench: expected apb read results land in a queue, a monitor compares reads with them.
 * assumes the regulator ticks every 100 clocks and answers apb with a wait state.
 */
`timescale 1ns/1ns
`default_nettype none
module pid_regulator_loss_sleep_test;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, st;
	logic pready, pslverr, comp, drive_run, fault_contact, lost;
	logic [15:0] a_in, b_in, p_in, pid_out, lvl = 16'h0, s;
	logic [1:0] src = 2'h0;
	logic [3:0] din = 4'h0;
	logic [31:0] rnd = 32'hF50C167E, ctrl, outr, fg;
	logic [32:0] expq[$];
	int mismatches = 0, n_compared = 0, cycles = 0;
	always #5 clk = ~clk;
	pid_regulator i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .analog_a_in(a_in), .analog_b_in(b_in), .pulse_freq_in(p_in),
		.din(din), .pid_output(pid_out), .output_is_compensation(comp),
		.drive_run(drive_run), .fault_contact(fault_contact), .feedback_lost_alarm(lost));
	fb_sensor i_fb (.clk(clk), .src(src), .level(lvl), .analog_a_in(a_in),
		.analog_b_in(b_in), .pulse_freq_in(p_in));
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; a read notes its expected error bit and data first
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] exp);
		if (!wr) expq.push_back(exp);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ticks(input int n);
		repeat (n * pid_pkg::SAMPLE_CYCLES) @(posedge clk);
	endtask
	// monitor: takes the oldest note when a read completes
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			mismatches++;
			stop_test();
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (expq.size() == 0) check(33'h0, 33'h1);
			else check({pslverr, prdata}, expq.pop_front());
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		apb(0, pid_pkg::ADDR_CTRL, 0, {1'b0, pid_pkg::CTRL_RESET});
		apb(0, pid_pkg::ADDR_PI, 0, {1'b0, pid_pkg::PI_RESET});
		apb(0, pid_pkg::ADDR_DI, 0, {1'b0, pid_pkg::DI_RESET});
		apb(0, pid_pkg::ADDR_OUT, 0, {1'b0, pid_pkg::OUT_RESET});
		apb(0, pid_pkg::ADDR_FG, 0, {1'b0, pid_pkg::FG_RESET});
		apb(0, pid_pkg::ADDR_PSCALE, 0, {1'b0, pid_pkg::PSCALE_RESET});
		apb(0, 8'h40, 0, {1'b1, 32'h0});
		apb(1, pid_pkg::ADDR_PI, 32'h0000_0100, 0);
		apb(1, pid_pkg::ADDR_DI, 32'h2710_0000, 0);
		// each feedback source in turn, seen on the monitor word
		for (int i = 0; i < 3; i++) begin
			src <= 2'(i);
			lvl <= 16'h03E8 + 16'(i);
			ctrl = (i == 0) ? 32'h0000_B101 : (i == 1) ? 32'h000B_0101 : 32'h0010_0101;
			apb(1, pid_pkg::ADDR_CTRL, ctrl, 0);
			ticks(3);
			apb(0, pid_pkg::ADDR_MON, 0, {1'b0, 16'h0, 16'h03E8 + 16'(i)});
		end
		src <= 2'h0;
		lvl <= 16'h03E8;
		// output chain cases with a random setpoint
		for (int c = 0; c < 8; c++) begin
			rnd = xs(rnd);
			s = 16'h07D0 + 16'(rnd[9:0]);
			ctrl = (c == 4) ? 32'h0000_B119 : (c == 5) ? 32'h0000_B139 :
				(c == 6) ? 32'h0000_B109 : (c == 7) ? 32'h0000_B103 : 32'h0000_B101;
			outr = (c == 1) ? 32'h0005_2710 : (c == 2) ? 32'h0000_01F4 : 32'h0000_2710;
			fg = (c == 3) ? 32'h0200_0000 : 32'h0100_0000;
			apb(1, pid_pkg::ADDR_SETPT, {16'h0, s}, 0);
			apb(1, pid_pkg::ADDR_CTRL, ctrl, 0);
			apb(1, pid_pkg::ADDR_OUT, outr, 0);
			apb(1, pid_pkg::ADDR_FG, fg, 0);
			ticks(4);
			st[15:0] = (c == 1) ? s - 16'h03B6 : (c == 2) ? 16'h01F4 : (c == 3) ?
				(s - 16'h03E8) << 1 : (c == 4) ? 16'h03E8 - s : (c > 4 && c < 7) ?
				16'h0 : s - 16'h03E8;
			st[31:16] = (c == 7) ? 16'h0011 : 16'h0001;
			check({17'h0, pid_out}, {17'h0, st[15:0]});
			check({32'h0, comp}, {32'h0, st[20]});
			apb(0, pid_pkg::ADDR_STATUS, 0, {1'b0, 11'h0, st[20:0]});
		end
		// feedback loss: warning keeps running, fault stops
		apb(1, pid_pkg::ADDR_LOSS, 32'h0003_01F4, 0);
		apb(1, pid_pkg::ADDR_CTRL, 32'h0000_B141, 0);
		lvl <= 16'h0064;
		ticks(6);
		check({lost, drive_run, fault_contact}, 3'b110);
		lvl <= 16'h03E8;
		ticks(2);
		check({32'h0, lost}, 33'h0);
		apb(1, pid_pkg::ADDR_CTRL, 32'h0000_B181, 0);
		lvl <= 16'h0064;
		ticks(6);
		check({drive_run, fault_contact}, 2'b01);
		lvl <= 16'h03E8;
		apb(1, pid_pkg::ADDR_CTRL, 32'h0000_B301, 0);
		// sleep below level, wake above it, none while disabled
		apb(1, pid_pkg::ADDR_SLEEP, 32'h0003_07D0, 0);
		apb(1, pid_pkg::ADDR_SETPT, 32'h0000_03E8, 0);
		ticks(6);
		check({32'h0, drive_run}, 33'h0);
		apb(1, pid_pkg::ADDR_SETPT, 32'h0000_0BB8, 0);
		ticks(6);
		check({32'h0, drive_run}, 33'h1);
		apb(1, pid_pkg::ADDR_CTRL, 32'h0000_B100, 0);
		apb(1, pid_pkg::ADDR_SETPT, 32'h0000_03E8, 0);
		ticks(6);
		check({32'h0, drive_run}, 33'h1);
		// soft starter paced by its step, bypassed by input code 34, then disable
		apb(1, pid_pkg::ADDR_SLEEP, 32'h0, 0);
		apb(1, pid_pkg::ADDR_DINF, 32'h1F1E_1322, 0);
		apb(1, pid_pkg::ADDR_RAMP, 32'h0000_0064, 0);
		apb(1, pid_pkg::ADDR_CTRL, 32'h0000_B101, 0);
		ticks(3);
		apb(1, pid_pkg::ADDR_SETPT, 32'h0000_07D0, 0);
		// first output change comes two ticks after the first ramp step
		@(pid_out);
		@(posedge clk);
		check({17'h0, pid_out}, {17'h0, 16'h0064});
		apb(0, pid_pkg::ADDR_MON, 0, {1'b0, 16'h0514, 16'h03E8});
		din <= 4'h1;
		ticks(2);
		apb(0, pid_pkg::ADDR_MON, 0, {1'b0, 16'h07D0, 16'h03E8});
		din <= 4'h2;
		ticks(3);
		apb(0, pid_pkg::ADDR_STATUS, 0, 33'h0);
		// integral: limited, held, then cleared by input codes
		din <= 4'h0;
		apb(1, pid_pkg::ADDR_RAMP, 32'h0, 0);
		apb(1, pid_pkg::ADDR_DI, 32'h0190_0000, 0);
		apb(1, pid_pkg::ADDR_PI, 32'h0001_0100, 0);
		ticks(4);
		check({17'h0, pid_out}, {17'h0, 16'h0578});
		din <= 4'h8;
		apb(1, pid_pkg::ADDR_SETPT, 32'h0000_0384, 0);
		ticks(4);
		check({17'h0, pid_out}, {17'h0, 16'h012C});
		din <= 4'h4;
		apb(1, pid_pkg::ADDR_SETPT, 32'h0000_044C, 0);
		ticks(4);
		check({17'h0, pid_out}, {17'h0, 16'h0064});
		// output filter with shift 1 halves the first step
		apb(1, pid_pkg::ADDR_PI, 32'h0000_0100, 0);
		din <= 4'h0;
		apb(1, pid_pkg::ADDR_FG, 32'h0100_0001, 0);
		ticks(2);
		apb(1, pid_pkg::ADDR_SETPT, 32'h0000_05DC, 0);
		@(pid_out);
		@(posedge clk);
		check({17'h0, pid_out}, {17'h0, 16'h012C});
		stop_test();
	end
endmodule
`default_nettype wire
